// ### core/sse_exec.sv
// ----------------------------------------
// Floating subtractor, round to nearest even.
// ----------------------------------------
module sse_fsub #(
  parameter int EW = 8,
  parameter int MW = 23
) (
  input  logic [EW+MW:0] x_i,   // Minuend.
  input  logic [EW+MW:0] y_i,   // Subtrahend.
  output logic [EW+MW:0] r_o,   // Difference.
  output logic           fx_o,  // Inexact.
  output logic           fu_o,  // Underflow.
  output logic           fv_o,  // Overflow.
  output logic           fi_o   // Invalid.
);
  localparam int M = MW + 4;   // Hidden bit, fraction, three guards.
  logic [EW-1:0] ex, ey, eb, es;
  logic [EW:0]   e;
  logic [M:0]    mb, ms, s;
  logic          sy, xn, yn, xinf, yinf, swap, sb, rnd;
  int            d;

  // Whole datapath in one pass; area was traded for zero latency.
  always_comb begin
    ex = x_i[EW+MW-1:MW];
    ey = y_i[EW+MW-1:MW];
    sy = ~y_i[EW+MW];  // Subtraction is addition of the negated y.
    xn = (&ex) & (|x_i[MW-1:0]);
    yn = (&ey) & (|y_i[MW-1:0]);
    xinf = (&ex) & ~(|x_i[MW-1:0]);
    yinf = (&ey) & ~(|y_i[MW-1:0]);
    swap = y_i[EW+MW-1:0] > x_i[EW+MW-1:0];
    sb = swap ? sy : x_i[EW+MW];
    eb = swap ? ey : ex;
    es = swap ? ex : ey;
    // Denormals carry exponent one and no hidden bit.
    if (eb == '0) begin
      eb = EW'(1);
    end
    if (es == '0) begin
      es = EW'(1);
    end
    mb = {1'b0, |(swap ? ey : ex), swap ? y_i[MW-1:0] : x_i[MW-1:0],
          3'b000};
    ms = {1'b0, |(swap ? ex : ey), swap ? x_i[MW-1:0] : y_i[MW-1:0],
          3'b000};
    d = int'(eb) - int'(es);
    // Alignment keeps every lost bit in a sticky guard.
    for (int k = 0; k <= M; k++) begin
      if (k < d) begin
        ms = {1'b0, ms[M:2], ms[1] | ms[0]};
      end
    end
    s = (x_i[EW+MW] ^ sy) ? mb - ms : mb + ms;
    e = {1'b0, eb};
    if (s[M]) begin
      s = {1'b0, s[M:2], s[1] | s[0]};
      e = e + 1'b1;
    end else begin
      for (int k = 0; k < M; k++) begin
        if (!s[M-1] && e > 1 && s != '0) begin
          s = s << 1;
          e = e - 1'b1;
        end
      end
    end
    fx_o = |s[2:0];
    rnd = s[2] & (s[1] | s[0] | s[3]);
    s = s + {{(M-3){1'b0}}, rnd, 3'b000};
    if (s[M]) begin
      s = s >> 1;
      e = e + 1'b1;
    end
    fu_o = ~s[M-1] & fx_o;
    fv_o = e >= {1'b0, {EW{1'b1}}};
    fi_o = 1'b0;
    if (s == '0) begin
      r_o = '0;
    end else if (fv_o) begin
      r_o = {sb, {EW{1'b1}}, {MW{1'b0}}};
      fx_o = 1'b1;
    end else begin
      r_o = {sb, s[M-1] ? e[EW-1:0] : {EW{1'b0}}, s[M-2:3]};
    end
    // Special operands override the arithmetic path.
    if (xn || yn) begin
      r_o = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
      fi_o = (xn & ~x_i[MW-1]) | (yn & ~y_i[MW-1]);
      {fx_o, fu_o, fv_o} = 3'b000;
    end else if (xinf || yinf) begin
      fi_o = xinf & yinf & (x_i[EW+MW] != sy);
      r_o = fi_o ? {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}}
                 : {xinf ? x_i[EW+MW] : sy, {EW{1'b1}}, {MW{1'b0}}};
      {fx_o, fu_o, fv_o} = 3'b000;
    end
  end
endmodule

// ----------------------------------------
// Execution unit for the shift, store, subtract group.
// ----------------------------------------
module sse_exec (
  // Clock and reset.
  input  logic             CLK_I,
  input  logic             RST_I,
  // Operation request.
  input  logic             OP_VALID_I,
  output logic             OP_READY_O,
  input  sse_pkg::sse_op_e OP_I,
  input  logic [31:0]      W1_I,      // Source, immediate or quick.
  input  logic [31:0]      W2_I,      // Destination, or pair low.
  input  logic [31:0]      W2_HI_I,   // Pair high word.
  input  logic [63:0]      F1_I,      // Float source.
  input  logic [63:0]      F2_I,      // Float destination.
  input  logic [31:0]      ADDR_I,    // Effective address.
  input  logic             IRQ_I,     // Pending interrupt.
  // Completion.
  output logic             DONE_O,
  output logic             WB_O,
  output logic [63:0]      RES_O,
  output logic             TRAP_O,
  output logic [3:0]       TRAP_CAUSE_O,
  output logic [7:0]       PSW_O,
  // Memory port.
  output logic             MEM_REQ_O,
  output logic             MEM_WE_O,
  output logic             MEM_LOCK_O,
  output logic [31:0]      MEM_ADDR_O,
  output logic [63:0]      MEM_WDATA_O,
  output logic [7:0]       MEM_BE_O,
  input  logic             MEM_ACK_I,
  input  logic             MEM_ERR_I,
  input  logic [1:0]       MEM_ERR_CODE_I,
  input  logic [31:0]      MEM_RDATA_I,
  // APB slave.
  input  logic             PSEL_I,
  input  logic             PENABLE_I,
  input  logic             PWRITE_I,
  input  logic [7:0]       PADDR_I,
  input  logic [31:0]      PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O
);
  import sse_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_MEM, S_LOCK_WR, S_WAIT} sse_st_e;

  sse_st_e     st_q;          // Sequencer state.
  logic [7:0]  ctrl_q;        // Software control.
  logic [7:0]  psw_q;         // processor_status_word flags.
  logic        ts_q;          // Memory access belongs to test-and-set.
  logic        done_q, wb_q, trap_q;
  logic [3:0]  cause_q;
  logic [63:0] res_q, wdata_q;
  logic [31:0] addr_q;
  logic [7:0]  be_q;
  logic        we_q;

  // ----------------------------------------
  // Decode.
  // ----------------------------------------
  wire take     = OP_VALID_I & OP_READY_O;
  wire is_store = OP_I inside {OP_ST_B, OP_ST_H, OP_ST_W, OP_ST_S,
                               OP_ST_D};
  wire is_flt   = OP_I inside {OP_FSUB_D, OP_FSUB_S};
  wire is_sub   = OP_I inside {OP_SUB_I, OP_SUB_Q, OP_SUB_W, OP_SUB_WC};
  wire is_xor   = OP_I inside {OP_XOR_I, OP_XOR_W};
  wire is_alu   = is_flt | is_sub | is_xor | OP_I == OP_SHIFT_W |
                  OP_I == OP_SHIFT_L;

  // ----------------------------------------
  // Shifter.
  // ----------------------------------------
  // Pair shifts take a 16-bit signed immediate.
  wire [31:0] cnt = (OP_I == OP_SHIFT_L) ? {{16{W1_I[15]}}, W1_I[15:0]}
                                         : W1_I;
  wire [31:0] mag = cnt[31] ? 32'(-cnt) : cnt;
  wire [63:0] pair = {W2_HI_I, W2_I};
  wire [31:0] sh_w = (mag > 32'd31) ? 32'h0000_0000 :
                     cnt[31] ? W2_I >> mag[4:0] :
                               W2_I << mag[4:0];
  wire [63:0] sh_l = (mag > 32'd63) ? 64'h0000_0000_0000_0000 :
                     cnt[31] ? pair >> mag[5:0] :
                               pair << mag[5:0];

  // ----------------------------------------
  // Integer subtract and exclusive-OR.
  // ----------------------------------------
  // Borrow comes out of bit 32 of the widened difference.
  wire        cin   = (OP_I == OP_SUB_WC) & psw_q[ST_C];
  wire [32:0] diff  = {1'b0, W2_I} - {1'b0, W1_I} - {32'd0, cin};
  wire        sgn_x = W2_I[31] ^ W1_I[31];
  // Quick form checks for a positive result instead.
  wire        sub_v = (OP_I == OP_SUB_Q) ? sgn_x & ~diff[31]
                      : sgn_x & (diff[31] == W1_I[31]);
  wire [31:0] xo    = W2_I ^ W1_I;

  // ----------------------------------------
  // Floating subtract, single and double.
  // ----------------------------------------
  logic [31:0] fs_r;
  logic [63:0] fd_r;
  logic [3:0]  fs_f, fd_f;   // {I, V, U, X}.
  sse_fsub #(.EW(8), .MW(23)) u_fs (
    .x_i  (F2_I[31:0]),
    .y_i  (F1_I[31:0]),
    .r_o  (fs_r),
    .fx_o (fs_f[0]),
    .fu_o (fs_f[1]),
    .fv_o (fs_f[2]),
    .fi_o (fs_f[3])
  );
  sse_fsub #(.EW(11), .MW(52)) u_fd (
    .x_i  (F2_I),
    .y_i  (F1_I),
    .r_o  (fd_r),
    .fx_o (fd_f[0]),
    .fu_o (fd_f[1]),
    .fv_o (fd_f[2]),
    .fi_o (fd_f[3])
  );
  wire [3:0] fflg = (OP_I == OP_FSUB_D) ? fd_f : fs_f;
  wire       ftrap = |(fflg & ctrl_q[CTRL_FTE+:4]);

  // ----------------------------------------
  // Result and condition code selection.
  // ----------------------------------------
  wire [63:0] alu_r =
      (OP_I == OP_SHIFT_W) ? {32'd0, sh_w} :
      (OP_I == OP_SHIFT_L) ? sh_l :
      (OP_I == OP_FSUB_D)  ? fd_r :
      (OP_I == OP_FSUB_S)  ? {32'd0, fs_r} :
      is_sub ? {32'd0, diff[31:0]} : {32'd0, xo};
  wire        wide  = OP_I == OP_SHIFT_L;
  wire        n_new = wide ? alu_r[63] : alu_r[31];
  wire        z_new = wide ? alu_r == '0 : alu_r[31:0] == '0;
  wire [3:0]  cc_new = {is_sub & diff[32], is_sub & sub_v, z_new, n_new};
  wire unord = psw_q[ST_Z] & psw_q[ST_N];

  // Store data keeps only the bytes the size names.
  wire [63:0] st_data =
      (OP_I == OP_ST_B) ? {56'd0, W2_I[7:0]} :
      (OP_I == OP_ST_H) ? {48'd0, W2_I[15:0]} :
      (OP_I == OP_ST_W) ? {32'd0, W2_I} :
      (OP_I == OP_ST_S) ? {32'd0, F2_I[31:0]} : F2_I;
  wire [7:0]  st_be =
      (OP_I == OP_ST_B) ? BE_B : (OP_I == OP_ST_H) ? BE_H :
      (OP_I == OP_ST_D) ? BE_D : BE_W;

  // ----------------------------------------
  // APB decode.
  // ----------------------------------------
  wire hit_c = PADDR_I == REG_CTRL;
  wire hit_s = PADDR_I == REG_STATUS;
  wire apb_w = PSEL_I & PENABLE_I & PWRITE_I;
  wire wr_c  = apb_w & hit_c;
  wire wr_s  = apb_w & hit_s;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~(hit_c | hit_s);
  assign PRDATA_O  = hit_c ? {24'd0, ctrl_q} :
                     hit_s ? {23'd0, st_q != S_IDLE, psw_q} : 32'd0;

  // Float flags are sticky; a new flag wins over a clear.
  wire [3:0] fset = (take & is_flt) ? fflg : 4'h0;
  wire [3:0] fkeep = psw_q[7:4] & ~(wr_s ? PWDATA_I[7:4] : 4'h0);
  wire [3:0] cc_d = (take & is_alu & ~is_flt) ? cc_new :
                    wr_s ? PWDATA_I[3:0] : psw_q[3:0];

  assign OP_READY_O = st_q == S_IDLE;
  assign MEM_REQ_O  = st_q == S_MEM || st_q == S_LOCK_WR;
  // Lock spans the read and the write of test-and-set.
  assign MEM_LOCK_O = MEM_REQ_O & ts_q;
  assign MEM_WE_O   = we_q;
  assign MEM_ADDR_O = addr_q;
  assign MEM_WDATA_O = wdata_q;
  assign MEM_BE_O   = be_q;
  assign DONE_O = done_q;
  assign WB_O   = wb_q;
  assign RES_O  = res_q;
  assign TRAP_O = trap_q;
  assign TRAP_CAUSE_O = cause_q;
  assign PSW_O  = psw_q;
  wire [3:0] mcause = TC_PAGE + {2'b00, MEM_ERR_CODE_I};

  // ----------------------------------------
  // Software registers.
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= CTRL_RST;
      psw_q  <= PSW_RST;
    end else begin
      if (wr_c) begin
        ctrl_q <= PWDATA_I[7:0];
      end
      psw_q <= {fkeep | fset, cc_d};
    end
  end

  // ----------------------------------------
  // Sequencer.
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= S_IDLE;
      {ts_q, done_q, wb_q, trap_q, we_q} <= 5'b00000;
      cause_q <= TC_NONE;
      res_q   <= 64'h0000_0000_0000_0000;
      wdata_q <= 64'h0000_0000_0000_0000;
      addr_q  <= 32'h0000_0000;
      be_q    <= 8'h00;
    end else begin
      {done_q, wb_q, trap_q} <= 3'b000;
      case (st_q)
        S_IDLE: begin
          if (take && is_alu) begin
            res_q  <= alu_r;
            wb_q   <= 1'b1;
            done_q <= ~(is_flt & ftrap);
            trap_q <= is_flt & ftrap;
            cause_q <= TC_FLOAT;
          end else if (take && OP_I == OP_TRAP_UNORD) begin
            done_q  <= ~unord;
            trap_q  <= unord;
            cause_q <= TC_ILL;
          end else if (take && OP_I == OP_WAIT) begin
            if (ctrl_q[CTRL_SUPV]) begin
              st_q <= S_WAIT;
            end else begin
              trap_q  <= 1'b1;
              cause_q <= TC_PRIV;
            end
          end else if (take) begin
            // Stores and test-and-set both start a memory access.
            st_q    <= S_MEM;
            ts_q    <= OP_I == OP_TEST_SET;
            we_q    <= is_store;
            addr_q  <= ADDR_I;
            wdata_q <= st_data;
            be_q    <= is_store ? st_be : BE_W;
          end
        end
        S_MEM, S_LOCK_WR: begin
          if (MEM_ACK_I && MEM_ERR_I) begin
            st_q    <= S_IDLE;
            trap_q  <= 1'b1;
            cause_q <= mcause;
            ts_q    <= 1'b0;
          end else if (MEM_ACK_I && ts_q && st_q == S_MEM) begin
            // Old word goes to w2; the write sets the lock bit.
            st_q    <= S_LOCK_WR;
            res_q   <= {32'd0, MEM_RDATA_I};
            wdata_q <= {32'd0, MEM_RDATA_I | LOCK_BIT};
            we_q    <= 1'b1;
          end else if (MEM_ACK_I) begin
            st_q   <= S_IDLE;
            done_q <= 1'b1;
            wb_q   <= ts_q;
            ts_q   <= 1'b0;
          end
        end
        S_WAIT: begin
          // Only an enabled interrupt ends the wait.
          if (IRQ_I && ctrl_q[CTRL_IE]) begin
            st_q   <= S_IDLE;
            done_q <= 1'b1;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_shl_left;
    take && OP_I == OP_SHIFT_W && !W1_I[31] && W1_I < 32
      |=> RES_O[31:0] == ($past(W2_I) << $past(W1_I[4:0])) && WB_O;
  endproperty
  a_shl_left: assert property (p_shl_left)
    else $error("left word shift result wrong");
  property p_shl_right;
    take && OP_I == OP_SHIFT_W && W1_I[31] && W1_I > 32'hFFFF_FFE0
      |=> RES_O[31:0] == ($past(W2_I) >> $past(32'(-W1_I)));
  endproperty
  a_shl_right: assert property (p_shl_right)
    else $error("right word shift result wrong");
  property p_big;
    take && OP_I == OP_SHIFT_W && !W1_I[31] && W1_I > 31
      |=> RES_O == '0 ##1 PSW_O[ST_Z];
  endproperty
  a_big: assert property (p_big)
    else $error("oversized shift not zero");
  property p_sub_z;
    take && OP_I inside {OP_SUB_W, OP_SUB_I} && W1_I == W2_I
      |=> PSW_O[ST_Z] && !PSW_O[ST_C] && RES_O == '0;
  endproperty
  a_sub_z: assert property (p_sub_z)
    else $error("equal subtract flags wrong");
  property p_xor;
    take && is_xor |=> !PSW_O[ST_V] && !PSW_O[ST_C];
  endproperty
  a_xor: assert property (p_xor)
    else $error("exclusive-OR left V or C set");
  property p_unord;
    take && OP_I == OP_TRAP_UNORD && unord
      |=> TRAP_O && TRAP_CAUSE_O == TC_ILL && !DONE_O;
  endproperty
  a_unord: assert property (p_unord)
    else $error("unordered check did not trap");
  property p_byte;
    take && OP_I == OP_ST_B
      |=> MEM_BE_O == BE_B && MEM_WDATA_O[63:8] == '0 && MEM_WE_O;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte store lanes wrong");
  property p_lock;
    st_q == S_MEM && ts_q && MEM_ACK_I && !MEM_ERR_I
      |=> MEM_LOCK_O && MEM_WE_O && MEM_WDATA_O[31];
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock dropped between read and write");
  property p_priv;
    take && OP_I == OP_WAIT && !ctrl_q[CTRL_SUPV]
      |=> TRAP_O && TRAP_CAUSE_O == TC_PRIV ##1 OP_READY_O;
  endproperty
  a_priv: assert property (p_priv)
    else $error("user wait did not trap");
  property p_fault;
    MEM_REQ_O && MEM_ACK_I && MEM_ERR_I
      |=> TRAP_O && !DONE_O && !MEM_REQ_O;
  endproperty
  a_fault: assert property (p_fault)
    else $error("memory fault not trapped");
  c_tas: cover property (st_q == S_LOCK_WR && MEM_ACK_I);
  c_wait: cover property (st_q == S_WAIT ##1 DONE_O);
  c_ftrap: cover property (TRAP_O && TRAP_CAUSE_O == TC_FLOAT);
endmodule

// ### core/sse_pkg.sv
// How it works
// - Word shift, positive count left, zero fill.
// - Negative word count shifts right, zeros in.
// - Pair shift by immediate, N from bit 63.
// - Byte store writes low byte only.
// - Halfword store writes low halfword only.
// - Word store writes all 32 bits.
// - Float stores write single or double register.
// - Stores trap on reported memory faults.
// - Double subtract puts f2 minus f1 in f2.
// - Float subtract sets four flags, may trap.
// - Single subtract puts s2 minus s1 in s2.
// - Immediate subtract writes w2 minus immediate.
// - Subtract sets N, Z, V and borrow.
// - Register subtract overflow uses subtrahend sign.
// - Quick subtract overflow: signs differ, positive.
// - Subtract with carry also subtracts carry.
// - Unordered flags raise illegal instruction trap.
// - Test-and-set loads word, sets bit 31.
// - Test-and-set read and write stay locked.
// - Wait stalls for interrupt; user mode traps.
// - Exclusive-OR sets N, Z, clears V, C.
package sse_pkg;
  // ----------------------------------------
  // Operations accepted from the decoder.
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_SHIFT_W, OP_SHIFT_L, OP_ST_B, OP_ST_H, OP_ST_W, OP_ST_S,
    OP_ST_D, OP_FSUB_D, OP_FSUB_S, OP_SUB_I, OP_SUB_Q, OP_SUB_W,
    OP_SUB_WC, OP_TRAP_UNORD, OP_TEST_SET, OP_WAIT, OP_XOR_I,
    OP_XOR_W
  } sse_op_e;
  // ----------------------------------------
  // Trap causes.
  // ----------------------------------------
  localparam logic [3:0] TC_NONE  = 4'h0;
  localparam logic [3:0] TC_PAGE  = 4'h1;  // Memory code 0.
  localparam logic [3:0] TC_ILL   = 4'h5;
  localparam logic [3:0] TC_PRIV  = 4'h6;
  localparam logic [3:0] TC_FLOAT = 4'h7;
  // ----------------------------------------
  // Register map and fields.
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_SUPV = 0;   // Supervisor mode.
  localparam int CTRL_IE   = 1;   // Interrupt enable.
  localparam int CTRL_FTE  = 4;   // Float trap enables [7:4].
  localparam int ST_N  = 0;
  localparam int ST_Z  = 1;
  localparam int ST_V  = 2;
  localparam int ST_C  = 3;
  localparam int ST_FX = 4;       // Float flags [7:4]: X U V I.
  localparam int ST_BUSY = 8;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] PSW_RST  = 8'h00;
  localparam logic [31:0] LOCK_BIT = 32'h8000_0000;
  // Byte enables for each store size.
  localparam logic [7:0] BE_B = 8'h01;
  localparam logic [7:0] BE_H = 8'h03;
  localparam logic [7:0] BE_W = 8'h0F;
  localparam logic [7:0] BE_D = 8'hFF;
endpackage

// ### verification/sse_mem_model.sv
// ----------------------------------------
// Memory system seen from the execution unit.
// ----------------------------------------
module sse_mem_model (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Access from the block.
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        lock_i,
  input  wire logic [63:0] wdata_i,
  // Scenario controls.
  input  wire logic [3:0]  delay_i,
  input  wire logic        fault_i,
  input  wire logic [31:0] word_i,
  // Answers and records.
  output logic             ack_o,
  output logic             err_o,
  output logic [31:0]      rdata_o,
  output logic [31:0]      wr_word_o,
  output logic             lock_o
);
  logic [3:0] cnt_q;  // Wait states spent on this access.

  // One access at a time; read data toggles outside the answer cycle so
  // that a stale value is never mistaken for a fresh one.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o     <= 1'b0;
      err_o     <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      wr_word_o <= 32'h0000_0000;
      lock_o    <= 1'b0;
      cnt_q     <= 4'h0;
    end else begin
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
        if (cnt_q == delay_i) begin
          ack_o  <= 1'b1;
          err_o  <= fault_i;
          cnt_q  <= 4'h0;
          lock_o <= lock_i;
          if (we_i) begin
            wr_word_o <= wdata_i[31:0];
          end else begin
            rdata_o <= word_i;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

// ### verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals.
  // ----------------------------------------
  logic CLK_I, RST_I, OP_VALID_I, IRQ_I, MEM_ACK_I, MEM_ERR_I, PSEL_I;
  logic PENABLE_I, PWRITE_I, OP_READY_O, DONE_O, WB_O, TRAP_O, MEM_REQ_O;
  logic MEM_WE_O, MEM_LOCK_O, PREADY_O, PSLVERR_O, fault, lock_seen, e;
  logic tr_s, wb_s;
  sse_pkg::sse_op_e OP_I;
  logic [31:0] W1_I, W2_I, W2_HI_I, ADDR_I, MEM_RDATA_I, MEM_ADDR_O;
  logic [31:0] PWDATA_I, PRDATA_O, wr_word, rd_word, q;
  logic [63:0] F1_I, F2_I, RES_O, MEM_WDATA_O, wd_s, m;
  logic [7:0]  PADDR_I, PSW_O, MEM_BE_O, be_s;
  logic [3:0]  TRAP_CAUSE_O, delay, cs_s;
  logic [1:0]  MEM_ERR_CODE_I;
  int          failures, samples_checked, n;
  sse_pkg::sse_op_e so[5] = '{sse_pkg::OP_ST_B, sse_pkg::OP_ST_H,
    sse_pkg::OP_ST_W, sse_pkg::OP_ST_S, sse_pkg::OP_ST_D};
  logic [7:0] sb[5] = '{sse_pkg::BE_B, sse_pkg::BE_H, sse_pkg::BE_W,
    sse_pkg::BE_W, sse_pkg::BE_D};

  initial CLK_I = 1'b0;
  always #50 CLK_I = ~CLK_I;  // 10 MHz.

  sse_exec i_sse_exec (.CLK_I, .RST_I, .OP_VALID_I, .OP_READY_O, .OP_I,
    .W1_I, .W2_I, .W2_HI_I, .F1_I, .F2_I, .ADDR_I, .IRQ_I, .DONE_O, .WB_O,
    .RES_O, .TRAP_O, .TRAP_CAUSE_O, .PSW_O, .MEM_REQ_O, .MEM_WE_O,
    .MEM_LOCK_O, .MEM_ADDR_O, .MEM_WDATA_O, .MEM_BE_O, .MEM_ACK_I,
    .MEM_ERR_I, .MEM_ERR_CODE_I, .MEM_RDATA_I, .PSEL_I, .PENABLE_I,
    .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O);
  sse_mem_model i_sse_mem_model (.clk_i(CLK_I), .rst_i(RST_I),
    .req_i(MEM_REQ_O), .we_i(MEM_WE_O), .lock_i(MEM_LOCK_O),
    .wdata_i(MEM_WDATA_O), .delay_i(delay), .fault_i(fault),
    .word_i(rd_word), .ack_o(MEM_ACK_I), .err_o(MEM_ERR_I),
    .rdata_o(MEM_RDATA_I), .wr_word_o(wr_word), .lock_o(lock_seen));

  // ----------------------------------------
  // Tasks.
  // ----------------------------------------
  task automatic chk(input logic [159:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Issues one operation and waits, bounded, for its completion pulse.
  task automatic op(input sse_pkg::sse_op_e o, input logic [31:0] a, b);
    @(posedge CLK_I);
    OP_I <= o;
    W1_I <= a;
    W2_I <= b;
    OP_VALID_I <= 1'b1;
    @(posedge CLK_I);
    OP_VALID_I <= 1'b0;
    n = 0;
    #1;  // One-cycle answers stand only until the next edge.
    while (DONE_O !== 1'b1 && TRAP_O !== 1'b1 && n < 300) begin
      @(posedge CLK_I);
      #1;
      n++;
      if (MEM_REQ_O === 1'b1) begin
        be_s = MEM_BE_O;
        wd_s = MEM_WDATA_O;
      end
    end
    tr_s = TRAP_O;
    wb_s = WB_O;
    cs_s = TRAP_CAUSE_O;
    if (n >= 300) chk(1'b0, 1'b1);
  endtask

  // Integer operation with result and flags {C,V,Z,N} compared.
  task automatic ar(input sse_pkg::sse_op_e o, input logic [31:0] a, b,
                    input logic [31:0] r, input logic [3:0] f);
    op(o, a, b);
    chk({wb_s, RES_O[31:0], PSW_O[3:0]}, {1'b1, r, f});
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLK_I); while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  task automatic end_sim;
    $display("Checks: %0d, mismatches: %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard at 30000 cycles, far beyond the few hundred cycles the tests need.
  initial begin
    #3000000;
    failures++;
    $display("Error at %0t ns: run timed out", $time);
    end_sim;
  end

  // ----------------------------------------
  // Tests.
  // ----------------------------------------
  initial begin
    RST_I = 1'b1; OP_VALID_I = 1'b0; IRQ_I = 1'b0; PSEL_I = 1'b0;
    PENABLE_I = 1'b0; PWRITE_I = 1'b0; OP_I = sse_pkg::OP_SHIFT_W;
    W1_I = '0; W2_I = '0; W2_HI_I = '0; F1_I = '0; F2_I = '0;
    ADDR_I = 32'h0000_0100;  // Plain memory, never ROM or I/O
    PADDR_I = '0; PWDATA_I = '0; delay = '0; fault = 1'b0;
    MEM_ERR_CODE_I = '0; rd_word = '0; failures = 0; samples_checked = 0;
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'b0;
    chk(PSW_O, sse_pkg::PSW_RST);
    apb(1'b0, sse_pkg::REG_CTRL, '0);
    chk(q, 32'h0000_0001);
    apb(1'b0, 8'h0C, '0);
    chk(e, 1'b1);
    op(sse_pkg::OP_SHIFT_W, 32'h0000_0004, 32'h0000_00FF);
    chk(RES_O[31:0], 32'h0000_0FF0);
    ar(sse_pkg::OP_SHIFT_W, '1, 32'h8000_0001, 32'h4000_0000, 4'h0);
    ar(sse_pkg::OP_SHIFT_W, 32, '1, '0, 4'h2);
    W2_HI_I <= 32'h7777_FFFF;
    op(sse_pkg::OP_SHIFT_L, 8, 32'h7777_FFFF);
    chk(RES_O, 64'h77FF_FF77_77FF_FF00);
    op(sse_pkg::OP_SHIFT_L, 32'hFFFF_FFF8, 32'h7777_FFFF);
    chk(RES_O, 64'h0077_77FF_FF77_77FF);
    W2_HI_I <= 32'h0080_0000;
    op(sse_pkg::OP_SHIFT_L, 8, '0);
    chk({RES_O, PSW_O[0]}, {64'h8000_0000_0000_0000, 1'b1});
    $display("Test shifts done");
    ar(sse_pkg::OP_SUB_W, 1, 32'h8000_0000, 32'h7FFF_FFFF, 4'h4);
    ar(sse_pkg::OP_SUB_Q, 1, 32'h8000_0000, 32'h7FFF_FFFF, 4'h4);
    ar(sse_pkg::OP_XOR_I, 32'hFE, 32'hC0FF_EE12, 32'hC0FF_EEEC, 4'h1);
    ar(sse_pkg::OP_SUB_W, 2, 1, 32'hFFFF_FFFF, 4'h9);
    ar(sse_pkg::OP_XOR_W, 32'hFFFF_0000, 32'h00FF_00FF, 32'hFF00_00FF,
       4'h1);
    ar(sse_pkg::OP_SUB_W, 2, 1, 32'hFFFF_FFFF, 4'h9);
    ar(sse_pkg::OP_SUB_WC, 3, 10, 6, 4'h0);
    ar(sse_pkg::OP_SUB_I, 32'h18, 32'h20, 8, 4'h0);
    ar(sse_pkg::OP_SUB_I, 5, 5, 0, 4'h2);
    ar(sse_pkg::OP_XOR_W, 7, 7, 0, 4'h2);
    apb(1'b1, sse_pkg::REG_STATUS, 32'h0000_0003);
    op(sse_pkg::OP_TRAP_UNORD, 0, 0);
    chk({tr_s, cs_s}, {1'b1, sse_pkg::TC_ILL});
    apb(1'b1, sse_pkg::REG_STATUS, 32'h0000_0001);
    op(sse_pkg::OP_TRAP_UNORD, 0, 0);
    chk(tr_s, 1'b0);
    $display("Test integer done");
    F1_I <= 64'h3FE0_0000_0000_0000;
    F2_I <= 64'h3FF0_0000_0000_0000;
    op(sse_pkg::OP_FSUB_D, 0, 0);
    chk(RES_O, 64'h3FE0_0000_0000_0000);
    F1_I <= 64'h0000_0000_3F80_0000;
    F2_I <= 64'h0000_0000_4040_0000;
    op(sse_pkg::OP_FSUB_S, 0, 0);
    chk(RES_O[31:0], 32'h4000_0000);
    F1_I <= 64'hFFEF_FFFF_FFFF_FFFF;
    F2_I <= 64'h7FEF_FFFF_FFFF_FFFF;
    op(sse_pkg::OP_FSUB_D, 0, 0);
    chk({tr_s, PSW_O[6]}, 2'b01);
    apb(1'b1, sse_pkg::REG_CTRL, 32'h0000_0041);
    op(sse_pkg::OP_FSUB_D, 0, 0);
    chk({tr_s, cs_s}, {1'b1, sse_pkg::TC_FLOAT});
    apb(1'b1, sse_pkg::REG_CTRL, 32'h0000_0001);
    $display("Test float done");
    W2_I <= 32'hA1B2_C3D4;
    F2_I <= 64'h1122_3344_5566_7788;
    for (int i = 0; i < 5; i++) begin
      delay <= 4'(i);  // Prompt first, slower each time.
      op(so[i], '0, 32'hA1B2_C3D4);
      for (int k = 0; k < 8; k++) m[8*k+:8] = {8{sb[i][k]}};
      // Lanes outside the store size must read as zero.
      m = m & (i < 3 ? 64'hA1B2_C3D4 : F2_I);
      chk({be_s, MEM_ADDR_O, wd_s, wr_word},
          {sb[i], 32'h0000_0100, m, m[31:0]});
    end
    fault <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      MEM_ERR_CODE_I <= 2'(c);
      op(sse_pkg::OP_ST_H, '0, '0);
      chk({tr_s, cs_s}, {1'b1, 4'(c + 1)});
    end
    fault <= 1'b0;
    rd_word <= 32'h1234_5678;
    op(sse_pkg::OP_TEST_SET, 0, 0);
    chk({wb_s, RES_O[31:0]}, {1'b1, 32'h1234_5678});
    chk({lock_seen, wr_word}, {1'b1, 32'h9234_5678});
    $display("Test memory done");
    apb(1'b1, sse_pkg::REG_CTRL, 32'h0000_0003);
    fork
      begin
        repeat (12) @(posedge CLK_I);
        IRQ_I <= 1'b1;
      end
    join_none
    op(sse_pkg::OP_WAIT, 0, 0);
    chk({tr_s, n > 9}, 2'b01);
    IRQ_I <= 1'b0;
    apb(1'b1, sse_pkg::REG_CTRL, 32'h0000_0002);
    op(sse_pkg::OP_WAIT, 0, 0);
    chk({tr_s, cs_s}, {1'b1, sse_pkg::TC_PRIV});
    $display("Test wait done");
    end_sim;
  end
endmodule
